// *** core/otp_pkg.sv ***
package otp_pkg;

	// run-mode window into the program memory
	localparam logic [19:0] RUN_LO_BASE = 20'h04000;
	localparam logic [19:0] RUN_LO_END  = 20'h07eff;
	localparam logic [19:0] RUN_HI_BASE = 20'hfff00;
	localparam logic [5:0]  RUN_HI_PAGE = 6'h3f;

	// programming-mode window, one contiguous range
	localparam logic [16:0] PROG_END    = 17'h03fff;

	localparam int          MEM_DEPTH   = 16384;
	localparam logic [7:0]  ERASED      = 8'hff;
	localparam logic [7:0]  BUS_IDLE    = 8'h00;

	// program pulse length, 0.1 ms
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          PULSE_NS      = 100000;
	localparam int          PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_PULSE  = 4'b0010,
		ST_COMMIT = 4'b0100,
		ST_HOLD   = 4'b1000
	} otp_state_t;

endpackage

// *** core/otp_mem.sv ***
`timescale 1ns/100ps
module otp_mem #(
	parameter int DEPTH = otp_pkg::MEM_DEPTH,
	parameter int AW    = $clog2(DEPTH),
	parameter int DW    = 8
) (
	input  wire logic          clk,
	input  wire logic [AW-1:0] addr,
	input  wire logic          wr_en,
	input  wire logic [DW-1:0] wr_data,
	output logic      [DW-1:0] rd_data
);

	logic [DW-1:0] cells [DEPTH];

	// blank part reads as all ones
	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			cells[i] = otp_pkg::ERASED;
		end
	end

	// plain always: the array is also preset by the initial block above
	always @(posedge clk) begin
		if (wr_en) begin
			cells[addr] <= wr_data;
		end
		rd_data <= cells[addr];
	end

endmodule

// *** core/otp_access.sv ***
// Notes on behaviour
// - In run mode the memory appears at 04000-07EFFH and FFF00-FFFFFH.
// - In programming mode the same memory appears as 0000-3FFFH.
// - In programming mode address bits 15..0 come in on port pins, the top bit (16) on its own pin.
// - In programming mode an 8-bit port is a two-way data bus for writes and read-backs.
// - In programming mode chip enable, output enable, program pulse and mode control are inputs.
// - After reset release the device runs in single-clock mode.
`timescale 1ns/100ps
module otp_access #(
	parameter int AW           = 14,
	parameter int PULSE_CYCLES = otp_pkg::PULSE_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        test_vpp,
	input  wire logic        reset_pin_n,
	input  wire logic        addr_top_bit,
	input  wire logic [7:0]  p3_in,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        prog_pulse_n,
	input  wire logic        progmode_ctrl,
	input  wire logic [19:0] cpu_addr,
	input  wire logic        cpu_rd,
	output logic      [7:0]  p3_out,
	output logic             p3_oe_n,
	output logic      [7:0]  cpu_data,
	output logic             cpu_valid,
	output logic             prog_mode,
	output logic             prog_done,
	output logic             single_clk_mode
);

	localparam int CW = $clog2(PULSE_CYCLES + 1);
	localparam logic [CW-1:0] CNT_LAST = CW'(PULSE_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////////////

	otp_pkg::otp_state_t state;
	otp_pkg::otp_state_t next_state;
	logic [CW-1:0]       cnt;
	logic [7:0]          addr_hi;
	logic [7:0]          addr_lo;
	logic [7:0]          wdata;
	logic [7:0]          rd_data;
	logic                cpu_rd_q;
	logic                cpu_hit_q;
	logic                prog_range_q;

	wire        prog_mode_w  = test_vpp & ~reset_pin_n;
	wire [16:0] prog_addr    = {addr_top_bit, addr_hi, addr_lo};
	wire        prog_range   = prog_addr <= otp_pkg::PROG_END;
	wire        cpu_lo_hit   = cpu_addr >= otp_pkg::RUN_LO_BASE && cpu_addr <= otp_pkg::RUN_LO_END;
	wire        cpu_hi_hit   = cpu_addr >= otp_pkg::RUN_HI_BASE;
	wire [AW-1:0] cpu_idx    = cpu_hi_hit ? AW'({otp_pkg::RUN_HI_PAGE, cpu_addr[7:0]})
	                                      : cpu_addr[AW-1:0];
	wire [AW-1:0] mem_addr   = prog_mode ? prog_addr[AW-1:0] : cpu_idx;
	wire        drive        = prog_mode & ~ce_n & ~oe_n;
	wire        pulse_start  = prog_mode & ~ce_n & oe_n & ~prog_pulse_n;
	wire        pulse_held   = prog_mode & ~ce_n & ~prog_pulse_n;
	wire        mem_we       = (state == otp_pkg::ST_COMMIT) && prog_range;
	// one-time cells only ever lose ones, so a repeat pulse cannot undo a bit
	wire [7:0]  mem_wdata    = rd_data & wdata;
	wire [7:0]  next_p3_out  = !drive ? otp_pkg::BUS_IDLE
	                         : prog_range_q ? rd_data : otp_pkg::ERASED;

	otp_mem #(
		.DEPTH (otp_pkg::MEM_DEPTH),
		.AW    (AW),
		.DW    (8)
	) u_mem (
		.clk     (core_clk),
		.addr    (mem_addr),
		.wr_en   (mem_we),
		.wr_data (mem_wdata),
		.rd_data (rd_data)
	);

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		next_state = state;
		case (state)
			otp_pkg::ST_IDLE: begin
				if (pulse_start) begin
					next_state = otp_pkg::ST_PULSE;
				end
			end
			otp_pkg::ST_PULSE: begin
				// a pulse cut short writes nothing
				if (!pulse_held) begin
					next_state = otp_pkg::ST_IDLE;
				end else if (cnt == CNT_LAST) begin
					next_state = otp_pkg::ST_COMMIT;
				end
			end
			otp_pkg::ST_COMMIT: next_state = otp_pkg::ST_HOLD;
			otp_pkg::ST_HOLD: begin
				// one write per pulse however long it is held
				if (prog_pulse_n || ce_n || !prog_mode) begin
					next_state = otp_pkg::ST_IDLE;
				end
			end
			default: next_state = otp_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state <= otp_pkg::ST_IDLE;
			cnt   <= '0;
			wdata <= otp_pkg::ERASED;
		end else begin
			state <= next_state;
			if (state == otp_pkg::ST_IDLE && pulse_start) begin
				wdata <= p3_in;
				cnt   <= CW'(1);
			end else if (state == otp_pkg::ST_PULSE) begin
				// stops one past the last compared value, so the width never wraps
				cnt <= cnt + CW'(1);
			end
		end
	end

	// address bytes share the data port: mode control high loads the upper byte,
	// chip enable high with mode control low loads the lower one
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			addr_hi <= '0;
			addr_lo <= '0;
		end else if (prog_mode) begin
			if (progmode_ctrl) begin
				addr_hi <= p3_in;
			end else if (ce_n) begin
				addr_lo <= p3_in;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			prog_mode       <= 1'b0;
			single_clk_mode <= 1'b1;
			prog_done       <= 1'b0;
			p3_out          <= otp_pkg::BUS_IDLE;
			p3_oe_n         <= 1'b1;
			prog_range_q    <= 1'b0;
			cpu_rd_q        <= 1'b0;
			cpu_hit_q       <= 1'b0;
			cpu_valid       <= 1'b0;
			cpu_data        <= otp_pkg::ERASED;
		end else begin
			prog_mode       <= prog_mode_w;
			single_clk_mode <= 1'b1;
			prog_done       <= state == otp_pkg::ST_COMMIT;
			p3_out          <= next_p3_out;
			p3_oe_n         <= ~drive;
			prog_range_q    <= prog_range;
			cpu_rd_q        <= cpu_rd & ~prog_mode;
			cpu_hit_q       <= cpu_lo_hit | cpu_hi_hit;
			cpu_valid       <= cpu_rd_q;
			if (cpu_rd_q) begin
				cpu_data <= cpu_hit_q ? rd_data : otp_pkg::ERASED;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	bus_drive_a: assert property (!p3_oe_n |-> $past(prog_mode & ~ce_n & ~oe_n))
		else $error("data bus driven without both enables low");
	bus_release_a: assert property ((ce_n || oe_n) |=> p3_oe_n)
		else $error("data bus not released");
	run_map_a: assert property (!prog_mode && cpu_addr >= otp_pkg::RUN_HI_BASE
		|-> mem_addr == {otp_pkg::RUN_HI_PAGE, cpu_addr[7:0]})
		else $error("upper run window mapped wrong");
	prog_map_a: assert property (prog_mode |-> mem_addr == prog_addr[AW-1:0])
		else $error("programming address not used");
	addr_capture_a: assert property (prog_mode && ce_n && !progmode_ctrl
		|=> addr_lo == $past(p3_in))
		else $error("low address byte not captured");
	write_data_a: assert property (mem_we |-> mem_wdata == (rd_data & wdata))
		else $error("programmed byte wrong");
	pulse_length_a: assert property (state == otp_pkg::ST_COMMIT
		|-> $past(cnt) == CNT_LAST && $past(!prog_pulse_n, 2))
		else $error("write without full program pulse");
	single_clock_a: assert property (single_clk_mode)
		else $error("not in single-clock mode");
	hi_capture_a: assert property (prog_mode && progmode_ctrl |=> addr_hi == $past(p3_in))
		else $error("high address byte not captured");
	data_latch_a: assert property (state == otp_pkg::ST_IDLE && pulse_start
		|=> wdata == $past(p3_in))
		else $error("write data not taken from the bus");
	short_pulse_a: assert property (state == otp_pkg::ST_PULSE && !pulse_held
		|=> state == otp_pkg::ST_IDLE)
		else $error("cut pulse did not abandon the write");
	commit_once_a: assert property (state == otp_pkg::ST_COMMIT
		|=> state == otp_pkg::ST_HOLD && prog_done)
		else $error("commit not followed by hold and done");
	out_range_a: assert property (drive && !prog_range_q |=> p3_out == otp_pkg::ERASED)
		else $error("address outside range not read as erased");
	bus_idle_a: assert property (p3_oe_n |-> p3_out == otp_pkg::BUS_IDLE)
		else $error("idle bus carries data");
	run_refuse_a: assert property (prog_mode |=> !cpu_rd_q)
		else $error("run read taken in programming mode");
	run_valid_a: assert property (cpu_rd_q |=> cpu_valid)
		else $error("run read not answered");

endmodule

// *** sim/otp_prog_model.sv ***
`timescale 1ns/100ps
module otp_prog_model (
	input  wire logic       core_clk,
	input  wire logic [7:0] p3_out,
	input  wire logic       p3_oe_n,
	output logic            test_vpp,
	output logic            reset_pin_n,
	output logic            addr_top_bit,
	output logic      [7:0] p3_in,
	output logic            ce_n,
	output logic            oe_n,
	output logic            prog_pulse_n,
	output logic            progmode_ctrl
);
	logic [7:0] dq;
	logic       drv;
	// a released bus shows a toggled pattern, never the last byte
	assign p3_in = !p3_oe_n ? p3_out : (drv ? dq : ~dq);
	initial begin
		{test_vpp, reset_pin_n, addr_top_bit, drv, dq} = 12'h400;
		{ce_n, oe_n, prog_pulse_n, progmode_ctrl} = 4'b1110;
	end
	task automatic mode(input logic on);
		@(negedge core_clk);
		test_vpp = on;
		reset_pin_n = !on;
		repeat (2) @(negedge core_clk);
	endtask
	// leaves the low byte driven so the address is not reloaded with junk
	task automatic addr(input logic [16:0] a);
		@(negedge core_clk);
		{addr_top_bit, drv, progmode_ctrl, ce_n, dq} = {a[16], 3'b111, a[15:8]};
		@(negedge core_clk);
		// logic levels only on address pins: no signature read is ever tried
		{progmode_ctrl, dq} = {1'b0, a[7:0]};
	endtask
	task automatic prog(input logic [16:0] a, input logic [7:0] d, input int n);
		addr(a);
		@(negedge core_clk);
		{dq, ce_n, prog_pulse_n} = {d, 2'b00};
		repeat (n) @(negedge core_clk);
		{prog_pulse_n, drv} = 2'b10;
	endtask
	task automatic rd(input logic [16:0] a, output logic [7:0] d, output logic en_n);
		addr(a);
		@(negedge core_clk);
		{drv, ce_n, oe_n} = 3'b000;
		repeat (3) @(negedge core_clk);
		{d, en_n} = {p3_out, p3_oe_n};
		{ce_n, oe_n} = 2'b11;
	endtask
endmodule

// *** sim/tb.sv ***
`timescale 1ns/100ps
module tb;
	localparam int PC = 8;
	localparam logic [16:0] PA [4] = '{17'h00000, 17'h03eff, 17'h03f00, 17'h03fff};
	localparam logic [7:0]  PD [4] = '{8'h5a, 8'h3c, 8'ha5, 8'hc3};
	localparam logic [19:0] RA [4] = '{20'h04000, 20'h07eff, 20'hfff00, 20'hfffff};
	logic        core_clk, nrst, cpu_rd, test_vpp, reset_pin_n, addr_top_bit;
	logic        ce_n, oe_n, prog_pulse_n, progmode_ctrl, p3_oe_n, cpu_valid;
	logic        prog_mode, prog_done, single_clk_mode;
	logic [19:0] cpu_addr;
	logic [7:0]  p3_in, p3_out, cpu_data;
	int          n_errors, checks_done, n_done;
	otp_access #(.PULSE_CYCLES(PC)) dut_u (.core_clk, .nrst, .test_vpp, .reset_pin_n,
		.addr_top_bit, .p3_in, .ce_n, .oe_n, .prog_pulse_n, .progmode_ctrl, .cpu_addr,
		.cpu_rd, .p3_out, .p3_oe_n, .cpu_data, .cpu_valid, .prog_mode, .prog_done,
		.single_clk_mode);
	otp_prog_model pm_u (.core_clk, .p3_out, .p3_oe_n, .test_vpp, .reset_pin_n,
		.addr_top_bit, .p3_in, .ce_n, .oe_n, .prog_pulse_n, .progmode_ctrl);
	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	always @(negedge core_clk) if (prog_done === 1'b1) n_done++;
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [19:0] seen, input logic [19:0] exp, input string m);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic run_rd(input logic [19:0] a, input logic [7:0] exp);
		int k;
		@(negedge core_clk);
		{cpu_addr, cpu_rd} = {a, 1'b1};
		@(negedge core_clk);
		cpu_rd = 0;
		for (k = 0; k < 4 && cpu_valid !== 1'b1; k++) @(negedge core_clk);
		if (k == 4) begin
			n_errors++;
			close_out();
		end else begin
			check(20'(cpu_data), 20'(exp), "run read");
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		check(20'(p3_oe_n), 20'h1, "bus idle");
		check(20'(prog_mode), 20'h0, "run mode");
		check(20'(single_clk_mode), 20'h1, "clock mode");
		$display("reset test done");
	endtask
	task automatic t_prog();
		logic [7:0] d;
		logic       e;
		pm_u.mode(1'b1);
		check(20'(prog_mode), 20'h1, "prog mode");
		foreach (PA[i]) pm_u.prog(PA[i], PD[i], PC + 2);
		pm_u.prog(PA[1], PD[1], PC + 2);
		// too short a pulse must leave the cell erased
		pm_u.prog(17'h00001, 8'h00, PC - 2);
		repeat (2) @(negedge core_clk);
		check(20'(n_done), 20'h5, "commit count");
		pm_u.prog(17'h10000, 8'h00, PC + 2);
		foreach (PA[i]) begin
			pm_u.rd(PA[i], d, e);
			check(20'(d), 20'(PD[i]), "verify");
			check(20'(e), 20'h0, "bus driven");
		end
		pm_u.rd(17'h00001, d, e);
		check(20'(d), 20'hff, "short pulse");
		pm_u.rd(17'h10000, d, e);
		check(20'(d), 20'hff, "outside range");
		repeat (2) @(negedge core_clk);
		check(20'(p3_oe_n), 20'h1, "bus released");
		cpu_rd = 1'b1;
		@(negedge core_clk);
		cpu_rd = 1'b0;
		@(negedge core_clk);
		check(20'(cpu_valid), 20'h0, "run read refused");
		$display("prog test done");
	endtask
	task automatic t_run();
		pm_u.mode(1'b0);
		check(20'(prog_mode), 20'h0, "back to run");
		foreach (RA[i]) run_rd(RA[i], PD[i]);
		run_rd(20'h07f00, 8'hff);
		run_rd(20'h04001, 8'hff);
		$display("run test done");
	endtask
	initial begin
		{nrst, cpu_rd, cpu_addr} = '0;
		repeat (2) @(negedge core_clk);
		nrst = 1;
		t_reset();
		t_prog();
		t_run();
		close_out();
	end
endmodule
